// [verilog/program_memory_table_read.sv]
// Program memory with fetch port, table-read path and programming/debug pins.
// Assumes the core holds a table request until done_o and owns pin muxing.
// The programming port writes words; table reads never block it.
// Data and clock pin inputs are asynchronous to mclk_i and are filtered here; prog_mode_i is registered once, unfiltered.
`timescale 1ns/1ps
`include "progmem_consts.svh"
module program_memory_table_read
    import progmem_pkg::*;
#(
    parameter int ADDR_W   = `PM_ADDR_W,
    parameter int DATA_W   = 16,
    parameter bit DEBUG_EN = 1'b1
) (
    // Clock and reset
    input  wire logic              mclk_i,
    input  wire logic              sys_rst_i,

    // Instruction fetch
    input  wire logic [ADDR_W-1:0] pc_i,
    output logic      [ADDR_W-1:0] fetch_addr_o,
    output logic      [DATA_W-1:0] fetch_word_o,

    // Table read request from core
    input  wire logic              tbl_req_i,
    input  wire logic              tbl_page_rel_i,
    input  wire logic [7:0]        tbl_ptr_low_i,
    input  wire logic [7:0]        tbl_ptr_high_i,
    input  wire logic [7:0]        tbl_dest_i,

    // Table read answer
    output logic                   stall_o,
    output logic                   done_o,
    output logic                   dm_we_o,
    output logic      [7:0]        dm_addr_o,
    output logic      [7:0]        dm_data_o,
    output logic      [7:0]        table_high_byte_latch_o,

    // Program memory write port from programming logic
    input  wire logic              pm_we_i,
    input  wire logic [ADDR_W-1:0] pm_waddr_i,
    input  wire logic [DATA_W-1:0] pm_wdata_i,

    // Programming mode select (pin-level strap from outside)
    input  wire logic              prog_mode_i,

    // Shared data pin: programming data / debug data-address
    input  wire logic              program_serial_data_i,
    input  wire logic              program_serial_data_oe_req_i,
    input  wire logic              program_serial_data_out_req_i,
    output logic                   program_serial_data_o,
    output logic                   program_serial_data_oe_o,

    // Shared clock pin: programming clock / debug clock
    input  wire logic              program_serial_clock_i,

    // Synchronised link levels towards programming and debug logic, plus registered pin ownership
    output logic                   link_data_o,
    output logic                   link_clock_o,
    output logic                   debug_active_o,
    output logic                   gpio_func_en_o
);
    // Offset bits inside one program page
    localparam int PAGE_W = $clog2(`PM_PAGE_WORDS);
    // Words held by the program array
    localparam int DEPTH  = 1 << ADDR_W;

    // program word array, written only by the programming port
    logic [DATA_W-1:0] mem [0:DEPTH-1];

    // All registered state of the unit
    typedef struct packed {
        // Table-read sequencer
        tbl_state_type     st;

        // Instruction fetch pipeline stage
        logic [ADDR_W-1:0] fetch_addr;
        logic [DATA_W-1:0] fetch_word;

        // Operands captured when a table read is taken
        logic [ADDR_W-1:0] tbl_addr;
        logic [7:0]        dest;

        // Handshake back to the core
        logic              stall;
        logic              done;

        // Data-memory write of the low byte
        logic              dm_we;
        logic [7:0]        dm_addr;
        logic [7:0]        dm_data;

        // Table high-byte latch
        logic [7:0]        table_high_byte_latch;

        // Three-stage pin synchronisers
        logic [2:0]        sd_sync;
        logic [2:0]        sc_sync;

        // Filtered pin levels
        logic              sd_lvl;
        logic              sc_lvl;

        // Registered pin driver
        logic              sd_out;
        logic              sd_oe;

        // Ownership of the shared pins
        logic              dbg;
        logic              gpio;
    } state_type;

    // Current state
    state_type         s_r;
    // Next state
    state_type         s_nxt;

    // Program word at the captured table address
    logic [DATA_W-1:0] rd_word;

    // Candidate table addresses
    logic [ADDR_W-1:0] full_addr;
    logic [ADDR_W-1:0] page_addr;

    // Upper byte of the word, zero where the word has no bit
    logic [7:0]        high_byte;

    // word read for the table path
    assign rd_word = mem[s_r.tbl_addr];

    // pointer concatenation, excess high bits dropped
    assign full_addr = ADDR_W'({tbl_ptr_high_i, tbl_ptr_low_i});

    // page base of current fetch plus page offset
    assign page_addr = {pc_i[ADDR_W-1:PAGE_W], tbl_ptr_low_i[PAGE_W-1:0]};

    // latch bits without a program-word bit stay zero
    for (genvar b = 0; b < 8; b++) begin : g_high
        if (b < DATA_W - 8) begin : g_used
            assign high_byte[b] = rd_word[8+b];
        end else begin : g_unused
            assign high_byte[b] = 1'b0;
        end
    end

    // Memory write port for programming
    always_ff @(posedge mclk_i) begin
        if (pm_we_i) begin
            mem[pm_waddr_i] <= pm_wdata_i;
        end
    end

    // Next-state logic
    always_comb begin
        s_nxt = s_r;

        // Single-cycle pulses fall back unless set below
        s_nxt.done  = 1'b0;
        s_nxt.dm_we = 1'b0;

        // fetch follows program counter one cycle later
        s_nxt.fetch_addr = pc_i;
        // Registered read keeps the fetch path one flop deep
        s_nxt.fetch_word = mem[pc_i];

        unique case (s_r.st)
            // Wait for a request
            ST_IDLE: begin
                if (tbl_req_i) begin
                    if (tbl_page_rel_i) begin
                        s_nxt.tbl_addr = page_addr;
                    end else begin
                        s_nxt.tbl_addr = full_addr;
                    end
                    s_nxt.dest  = tbl_dest_i;
                    s_nxt.stall = 1'b1;
                    s_nxt.st    = ST_READ;
                end
            end

            // Second cycle: deliver both bytes
            ST_READ: begin
                s_nxt.dm_we   = 1'b1;
                s_nxt.dm_addr = s_r.dest;
                s_nxt.dm_data = rd_word[7:0];
                // only a table read loads the latch
                s_nxt.table_high_byte_latch  = high_byte;
                s_nxt.done  = 1'b1;
                s_nxt.stall = 1'b0;
                s_nxt.st    = ST_DONE;
            end

            // Gap after completion
            ST_DONE: begin
                // One idle slot so a held request is not repeated
                s_nxt.st = ST_IDLE;
            end
        endcase

        // Pin synchronisers, change counts when stages two and three agree
        s_nxt.sd_sync = {s_r.sd_sync[1:0], program_serial_data_i};
        s_nxt.sc_sync = {s_r.sc_sync[1:0], program_serial_clock_i};
        // Data and clock levels move only on two agreeing samples
        if (s_r.sd_sync[2] == s_r.sd_sync[1]) begin
            s_nxt.sd_lvl = s_r.sd_sync[2];
        end
        if (s_r.sc_sync[2] == s_r.sc_sync[1]) begin
            s_nxt.sc_lvl = s_r.sc_sync[2];
        end

        // single two-way data pin driven on request
        s_nxt.sd_out = program_serial_data_out_req_i;
        s_nxt.sd_oe  = program_serial_data_oe_req_i;

        // debug variant owns pins; programming still uses them
        s_nxt.dbg  = DEBUG_EN & ~prog_mode_i;
        // ordinary function off while debug or programming owns pins
        s_nxt.gpio = ~s_nxt.dbg & ~prog_mode_i;
    end

    // State register with synchronous reset
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            // Sequencer back to idle, no operation pending
            s_r.st         <= ST_IDLE;

            s_r.fetch_addr <= `PM_RESET_VECTOR;
            s_r.fetch_word <= '0;

            // Captured operands cleared
            s_r.tbl_addr   <= '0;
            s_r.dest       <= '0;

            // Handshake and write strobe low
            s_r.stall      <= 1'b0;
            s_r.done       <= 1'b0;
            s_r.dm_we      <= 1'b0;
            s_r.dm_addr    <= '0;
            s_r.dm_data    <= '0;

            // Latch starts empty
            s_r.table_high_byte_latch       <= `PM_TABLE_HIGH_BYTE_LATCH_RESET;

            // Synchronisers and filtered levels low
            s_r.sd_sync    <= '0;
            s_r.sc_sync    <= '0;
            s_r.sd_lvl     <= 1'b0;
            s_r.sc_lvl     <= 1'b0;

            // Data pin released
            s_r.sd_out     <= 1'b0;
            s_r.sd_oe      <= 1'b0;

            // Pin ownership settles on the first edge after reset
            s_r.dbg        <= 1'b0;
            s_r.gpio       <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Fetch outputs
    assign fetch_addr_o            = s_r.fetch_addr;
    assign fetch_word_o            = s_r.fetch_word;

    // Table-read handshake and data write
    assign stall_o                 = s_r.stall;
    assign done_o                  = s_r.done;
    assign dm_we_o                 = s_r.dm_we;
    assign dm_addr_o               = s_r.dm_addr;
    assign dm_data_o               = s_r.dm_data;

    assign table_high_byte_latch_o = s_r.table_high_byte_latch;

    assign program_serial_data_o    = s_r.sd_out;
    assign program_serial_data_oe_o = s_r.sd_oe;

    assign link_data_o             = s_r.sd_lvl;
    assign link_clock_o            = s_r.sc_lvl;

    assign debug_active_o          = s_r.dbg;
    assign gpio_func_en_o          = s_r.gpio;
endmodule

// [verilog/progmem_consts.svh]
// Constants of the program memory table-read unit.
// Included by the package and the design module.
`ifndef PROGMEM_CONSTS_SVH
`define PROGMEM_CONSTS_SVH
`define PM_RESET_VECTOR   14'h0000
`define PM_WORDS          16384
`define PM_ADDR_W         14
`define PM_PAGE_WORDS     256
`define PM_TABLE_HIGH_BYTE_LATCH_RESET     8'h00
`define PM_TBL_CYCLES     2'h2
`endif

// [verilog/progmem_pkg.sv]
// Types of the program memory table-read unit.
// No surroundings assumed.
`include "progmem_consts.svh"
package progmem_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_READ,
        ST_DONE
    } tbl_state_type;
endpackage

// [test/pm_sva.sv]
// Port assertions of the table-read unit.
// Bound to the design top; one clock, sync reset.
`timescale 1ns/1ps
module pm_sva #(parameter int ADDR_W = 14) (
    input wire logic mclk_i, sys_rst_i, tbl_req_i, tbl_page_rel_i,
    input wire logic stall_o, done_o, dm_we_o, prog_mode_i,
    input wire logic debug_active_o, gpio_func_en_o,
    input wire logic program_serial_data_oe_req_i,
    input wire logic program_serial_data_oe_o,
    input wire logic [ADDR_W-1:0] pc_i, fetch_addr_o,
    input wire logic [7:0] tbl_dest_i, dm_addr_o, table_high_byte_latch_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    op_timing_a: assert property (tbl_req_i && !stall_o && !done_o &&
        !$past(done_o) |=> stall_o ##1 (done_o && !stall_o))
        else $error("table op timing wrong");
    stall_once_a: assert property (stall_o |=> !stall_o)
        else $error("stall longer than one cycle");
    write_pulse_a: assert property (done_o |-> dm_we_o)
        else $error("no data write at done");
    dest_reg_a: assert property (done_o |-> dm_addr_o == $past(tbl_dest_i, 2))
        else $error("wrong destination register");
    latch_hold_a: assert property (!done_o |->
        $stable(table_high_byte_latch_o)) else $error("latch changed");
    reset_vec_a: assert property ($fell(sys_rst_i) |-> fetch_addr_o == '0)
        else $error("fetch not at zero after reset");
    fetch_follow_a: assert property (!$past(sys_rst_i) |->
        fetch_addr_o == $past(pc_i)) else $error("fetch address wrong");
    gpio_off_a: assert property (gpio_func_en_o |->
        !debug_active_o && !$past(prog_mode_i))
        else $error("pin function on");
    oe_follow_a: assert property (!$past(sys_rst_i) |->
        program_serial_data_oe_o == $past(program_serial_data_oe_req_i))
        else $error("data pin enable wrong");
    cover property (done_o && tbl_page_rel_i);
    cover property (done_o && !tbl_page_rel_i);
    cover property (program_serial_data_oe_o && prog_mode_i);
endmodule
bind program_memory_table_read pm_sva #(.ADDR_W(ADDR_W)) u_pm_sva (.*);

// [test/core_partner.sv]
// Core side model issuing table-read requests.
// Assumes go_i pulses one cycle; the bench holds operands.
`timescale 1ns/1ps
module core_partner (
    input  wire logic mclk_i,
    input  wire logic sys_rst_i,
    input  wire logic go_i,
    input  wire logic done_i,
    output logic      req_o
);
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || done_i) req_o <= 1'b0;
        else if (go_i) req_o <= 1'b1;
    end
endmodule

// [test/program_memory_table_read_tb.sv]
// Bench of the table-read unit: row table, then pin and latch cases.
// Assumes the design top and core_partner are compiled first.
`timescale 1ns/1ps
module program_memory_table_read_tb;
    typedef struct {logic [7:0] ph, pl; logic [13:0] pc; logic pg;
        logic [7:0] dst; logic [15:0] wd;} row_type;
    logic mclk_i = 0, sys_rst_i = 1, go = 0, pg = 0, we = 0, pm = 0;
    logic sd = 0, oer = 0, outr = 0, sck = 0, req, stl, dn, dwe;
    logic sdo, sdoe, ld, lc, dbg, gpe;
    logic [13:0] pc = 0, wa = 0, fa;
    logic [15:0] wd = 0, fw;
    logic [7:0] ph = 0, pl = 0, dst = 0, dma, dmd, lat;
    int bad_count = 0, n_checks = 0;
    row_type rows [5] = '{'{8'h0f, 8'h06, 14'h0, 0, 8'h80, 16'h001a},
        '{8'h0f, 8'h05, 14'h0, 0, 8'h81, 16'h000f},
        '{8'hff, 8'hff, 14'h0, 0, 8'h82, 16'ha55a},
        '{8'h00, 8'h33, 14'h2a10, 1, 8'h83, 16'h7e81},
        '{8'h00, 8'h00, 14'h0, 0, 8'hff, 16'hc3c3}};
    core_partner u_core_partner (.mclk_i, .sys_rst_i, .go_i(go),
        .done_i(dn), .req_o(req));
    program_memory_table_read u_program_memory_table_read (.mclk_i,
        .sys_rst_i, .pc_i(pc), .fetch_addr_o(fa), .fetch_word_o(fw),
        .tbl_req_i(req), .tbl_page_rel_i(pg), .tbl_ptr_low_i(pl),
        .tbl_ptr_high_i(ph), .tbl_dest_i(dst), .stall_o(stl), .done_o(dn),
        .dm_we_o(dwe), .dm_addr_o(dma), .dm_data_o(dmd),
        .table_high_byte_latch_o(lat), .pm_we_i(we), .pm_waddr_i(wa),
        .pm_wdata_i(wd), .prog_mode_i(pm), .program_serial_data_i(sd),
        .program_serial_data_oe_req_i(oer),
        .program_serial_data_out_req_i(outr), .program_serial_data_o(sdo),
        .program_serial_data_oe_o(sdoe), .program_serial_clock_i(sck),
        .link_data_o(ld), .link_clock_o(lc), .debug_active_o(dbg),
        .gpio_func_en_o(gpe));
    initial forever #25 mclk_i = ~mclk_i;
    function automatic logic [13:0] adr(row_type r);
        return r.pg ? {r.pc[13:8], r.pl} : 14'({r.ph, r.pl});
    endfunction
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // One table read through the partner, bounded wait for done
    task automatic rd(row_type r);
        @(posedge mclk_i);
        {ph, pl, pc, pg, dst, go} <= {r.ph, r.pl, r.pc, r.pg, r.dst, 1'b1};
        @(posedge mclk_i);
        go <= 0;
        for (int k = 0; k < 8 && dn !== 1; k++) @(negedge mclk_i);
        if (dn !== 1) begin
            bad_count++;
            tally_and_finish();
        end
    endtask
    initial begin
        repeat (12) @(posedge mclk_i);
        sys_rst_i <= 0;
        @(negedge mclk_i);
        chk("fetch_addr", 0, fa);
        chk("latch", 0, lat);
        foreach (rows[i]) begin
            @(posedge mclk_i);
            {we, wa, wd} <= {1'b1, adr(rows[i]), rows[i].wd};
        end
        @(posedge mclk_i);
        we <= 0;
        foreach (rows[i]) begin
            rd(rows[i]);
            chk("dm_we", 1, dwe);
            chk("dm_data", rows[i].wd[7:0], dmd);
            chk("latch", rows[i].wd[15:8], lat);
            chk("dm_addr", rows[i].dst, dma);
        end
        foreach (rows[i]) begin
            @(posedge mclk_i);
            pc <= adr(rows[i]);
            @(posedge mclk_i);
            @(negedge mclk_i);
            chk("fetch_word", rows[i].wd, fw);
        end
        @(posedge mclk_i);
        {we, wa, wd} <= {1'b1, 14'h0, 16'h5aa5};
        @(posedge mclk_i);
        {we, pc} <= {1'b0, 14'h0};
        repeat (2) @(negedge mclk_i);
        chk("latch", 16'h00c3, lat);
        chk("fetch_word", 16'h5aa5, fw);
        @(posedge mclk_i);
        {pm, oer, outr, sck, sd} <= 5'h1f;
        repeat (5) @(negedge mclk_i);
        chk("gpio_en", 0, gpe);
        chk("debug_act", 0, dbg);
        chk("data_oe", 1, sdoe);
        chk("data_out", 1, sdo);
        chk("link_clk", 1, lc);
        chk("link_dat", 1, ld);
        @(posedge mclk_i);
        {pm, sck, sd} <= 3'h0;
        repeat (4) @(negedge mclk_i);
        chk("debug_act", 1, dbg);
        chk("gpio_en", 0, gpe);
        // Second reset in mid-run with a non-zero program counter
        @(posedge mclk_i);
        {sys_rst_i, pc} <= {1'b1, 14'h0123};
        repeat (2) @(posedge mclk_i);
        sys_rst_i <= 0;
        @(negedge mclk_i);
        chk("fetch_addr", 0, fa);
        chk("latch", 0, lat);
        chk("dm_we", 0, dwe);
        tally_and_finish();
    end
endmodule
